/* File: rtl/lbcr_pkg.sv */
/*
 Constants, field layout and types for the lane B2/B3 configuration
 register slice of the repeater.
 Assumes a single 20 MHz management clock.
*/
// Notes on behaviour
// RQ1: B2 assert threshold at 0x20[3:2], reset 0
// RQ2: B2 de-assert threshold at 0x20[1:0]
// RQ3: thresholds from register only under override bit
// RQ4: B3 code 00 Hi-Z, code 11 50 ohm
// RQ5: code 01 probes every 12 ms, 50 tries
// RQ6: code 10 probes every 12 ms until found
// RQ7: detect code from register only under override
// RQ8: B3 equalizer byte at 0x24, reset 0x2F
// RQ9: 0x25 bit 7 enables short protection
// RQ10: 0x25[2:0] swing ratio, reset 0xAD
// RQ11: read-only bit 7 reports termination state
// RQ12: host writes zeros to reserved fields
package lbcr_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_B2_THRESH = 8'h20;
   localparam logic [7:0] ADDR_RSVD_A = 8'h21;
   localparam logic [7:0] ADDR_RSVD_B = 8'h22;
   localparam logic [7:0] ADDR_B3_TERM = 8'h23;
   localparam logic [7:0] ADDR_B3_EQ = 8'h24;
   localparam logic [7:0] ADDR_B3_SWING = 8'h25;
   localparam logic [7:0] ADDR_B3_STATUS = 8'h26;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_B2_THRESH = 8'h00;
   localparam logic [7:0] RST_RSVD = 8'h00;
   localparam logic [7:0] RST_B3_TERM = 8'h00;
   localparam logic [7:0] RST_B3_EQ = 8'h2F;
   localparam logic [7:0] RST_B3_SWING = 8'hAD;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ASSERT_LSB = 2;
   localparam int DEASSERT_LSB = 0;
   localparam int TERM_LSB = 2;
   localparam int SHORT_BIT = 7;
   localparam int SWING_LSB = 0;
   localparam int STATUS_BIT = 7;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int PROBE_PERIOD_MS = 12;
   localparam int PROBE_PERIOD_CYCLES = CLK_HZ / 1000 * PROBE_PERIOD_MS;
   localparam int PROBE_LIMIT = 50;

   // termination / presence-check modes
   typedef enum logic [1:0]
   {
      TERM_HIZ = 2'b00,
      TERM_AUTO_LIMITED = 2'b01,
      TERM_AUTO_ENDLESS = 2'b10,
      TERM_50 = 2'b11
   } lbcr_term_e;

   // two-bit field of a register byte
   function automatic logic [1:0] lbcr_field2(input logic [7:0] b, input int lsb);
      lbcr_field2 = b[lsb +: 2];
   endfunction
endpackage

/* File: rtl/lbcr_probe_seq.sv */
/*
 Lane B3 receiver presence check sequencer: probes the output at a
 fixed period and switches input termination once a receiver is seen.
 Assumes far_end_seen answers in the same cycle as the probe pulse.
*/
`timescale 1ns/1ps
module lbcr_probe_seq
#(
   parameter int PERIOD_CYCLES = 240000,
   parameter int LIMIT = 50
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire lbcr_pkg::lbcr_term_e mode,
   input wire logic far_end_seen,
   output logic probe,
   output logic terminated
);
   import lbcr_pkg::*;

   localparam int CW = $clog2(PERIOD_CYCLES + 1);
   localparam int TW = $clog2(LIMIT + 1);

   generate
      // a period of two would let probes come on every other edge
      if (PERIOD_CYCLES < 3 || LIMIT < 1)
      begin : g_bad
         $error("probe period or limit too small");
      end
   endgenerate

   typedef enum logic [1:0]
   {
      ST_OFF = 2'b00,
      ST_WAIT = 2'b01,
      ST_FOUND = 2'b10,
      ST_GAVEUP = 2'b11
   } lbcr_seq_e;

   lbcr_seq_e state, next_state;
   lbcr_term_e mode_q, next_mode_q;
   logic [CW-1:0] cnt, next_cnt;
   logic [TW-1:0] tries, next_tries;
   logic next_probe, next_terminated;

   // next state; a mode change restarts the whole sequence
   always_comb
   begin
      next_state = state;
      next_mode_q = mode;
      next_cnt = cnt;
      next_tries = tries;
      next_probe = 1'b0;
      next_terminated = terminated;
      if (mode != mode_q)
      begin
         next_cnt = '0;
         next_tries = '0;
         next_terminated = (mode == TERM_50); // [RQ4]
         next_state = (mode == TERM_AUTO_LIMITED || mode == TERM_AUTO_ENDLESS) ?
                      ST_WAIT : ST_OFF;
      end
      else
      begin
         unique case (state)
            ST_OFF, ST_FOUND, ST_GAVEUP:
            begin
               next_cnt = cnt;
            end
            ST_WAIT:
            begin
               // probe pulse is out this cycle: look at the answer first
               if (probe && far_end_seen)
               begin
                  next_state = ST_FOUND;
                  next_terminated = 1'b1; // [RQ5] [RQ6]
               end
               else if (probe && mode_q == TERM_AUTO_LIMITED && tries == TW'(LIMIT))
               begin
                  next_state = ST_GAVEUP; // [RQ5]
               end
               else if (cnt == CW'(PERIOD_CYCLES - 1))
               begin
                  next_cnt = '0;
                  next_probe = 1'b1; // [RQ5] [RQ6]
                  if (tries != TW'(LIMIT))
                  begin
                     next_tries = tries + TW'(1);
                  end
               end
               else
               begin
                  next_cnt = cnt + CW'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= ST_OFF;
         mode_q <= TERM_HIZ;
         cnt <= '0;
         tries <= '0;
         probe <= 1'b0;
         terminated <= 1'b0;
      end
      else
      begin
         state <= next_state;
         mode_q <= next_mode_q;
         cnt <= next_cnt;
         tries <= next_tries;
         probe <= next_probe;
         terminated <= next_terminated;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_probe_alone;
      @(posedge clk) disable iff (!rst_b)
      probe |=> !probe [*2];
   endproperty
   a_probe_alone: assert property (p_probe_alone) else $error("probe not isolated"); // [RQ6]

   property p_found_terms;
      @(posedge clk) disable iff (!rst_b)
      (probe && far_end_seen && mode == mode_q && state == ST_WAIT) |=> terminated;
   endproperty
   a_found_terms: assert property (p_found_terms) else $error("no 50 ohm after detect"); // [RQ5]

   property p_fixed_modes;
      @(posedge clk) disable iff (!rst_b)
      (mode == mode_q && (mode == TERM_HIZ || mode == TERM_50)) |=>
         (terminated == ($past(mode) == TERM_50));
   endproperty
   a_fixed_modes: assert property (p_fixed_modes) else $error("fixed termination wrong"); // [RQ4]

   property p_limited_stops;
      @(posedge clk) disable iff (!rst_b)
      (mode_q == TERM_AUTO_LIMITED && tries == TW'(LIMIT)) |-> ##1 !next_probe;
   endproperty
   a_limited_stops: assert property (p_limited_stops) else $error("probe after limit"); // [RQ5]

   c_found: cover property (@(posedge clk) disable iff (!rst_b) state == ST_FOUND);
   c_gaveup: cover property (@(posedge clk) disable iff (!rst_b) state == ST_GAVEUP);
endmodule

/* File: rtl/lbcr_regs.sv */
/*
 Lane B2/B3 configuration registers 0x20-0x26 with effective setting
 outputs for the analog lanes.
 Assumes the management engine (serial slave or EEPROM loader) gives
 one-cycle read and write strobes with an 8-bit offset, and that the
 global override bits arrive as levels from register 0x08.
*/
`timescale 1ns/1ps
module lbcr_regs
#(
   parameter int PROBE_CYCLES = lbcr_pkg::PROBE_PERIOD_CYCLES,
   parameter int PROBE_TRIES = lbcr_pkg::PROBE_LIMIT
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic override_threshold,
   input wire logic override_presence,
   input wire logic [1:0] threshold_pin_assert,
   input wire logic [1:0] threshold_pin_deassert,
   input wire lbcr_pkg::lbcr_term_e presence_pin,
   input wire logic far_end_seen,
   output logic [1:0] lane_b2_assert_threshold,
   output logic [1:0] lane_b2_deassert_threshold,
   output logic [7:0] lane_b3_equalizer,
   output logic lane_b3_short_protect,
   output logic [2:0] lane_b3_output_swing,
   output logic lane_b3_probe,
   output logic lane_b3_terminated
);
   import lbcr_pkg::*;

   generate
      if (PROBE_CYCLES < 3 || PROBE_TRIES < 1)
      begin : g_bad
         $error("probe parameters out of range");
      end
   endgenerate

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] b2_thresh, next_b2_thresh;
   logic [7:0] rsvd_a, next_rsvd_a;
   logic [7:0] rsvd_b, next_rsvd_b;
   logic [7:0] b3_term, next_b3_term;
   logic [7:0] b3_swing, next_b3_swing;
   logic [7:0] next_lane_b3_equalizer;

   // writes; reserved bits are stored as written, zeros expected [RQ12]
   always_comb
   begin
      next_b2_thresh = b2_thresh;
      next_rsvd_a = rsvd_a;
      next_rsvd_b = rsvd_b;
      next_b3_term = b3_term;
      next_b3_swing = b3_swing;
      next_lane_b3_equalizer = lane_b3_equalizer;
      if (reg_wr)
      begin
         unique case (reg_addr)
            ADDR_B2_THRESH: next_b2_thresh = reg_wdata; // [RQ1] [RQ2]
            ADDR_RSVD_A: next_rsvd_a = reg_wdata;
            ADDR_RSVD_B: next_rsvd_b = reg_wdata;
            ADDR_B3_TERM: next_b3_term = reg_wdata; // [RQ4]
            ADDR_B3_EQ: next_lane_b3_equalizer = reg_wdata; // [RQ8]
            ADDR_B3_SWING: next_b3_swing = reg_wdata; // [RQ9] [RQ10]
            default: next_b2_thresh = b2_thresh; // status and others ignore writes
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         b2_thresh <= RST_B2_THRESH;
         rsvd_a <= RST_RSVD;
         rsvd_b <= RST_RSVD;
         b3_term <= RST_B3_TERM;
         b3_swing <= RST_B3_SWING;
         lane_b3_equalizer <= RST_B3_EQ;
      end
      else
      begin
         b2_thresh <= next_b2_thresh;
         rsvd_a <= next_rsvd_a;
         rsvd_b <= next_rsvd_b;
         b3_term <= next_b3_term;
         b3_swing <= next_b3_swing;
         lane_b3_equalizer <= next_lane_b3_equalizer;
      end
   end

   // ----------------------------------------------------------------
   // effective settings
   // ----------------------------------------------------------------
   logic [1:0] next_assert, next_deassert;
   logic next_short;
   logic [2:0] next_swing;
   lbcr_term_e eff_mode;

   // threshold and presence-mode register fields win only while their override bit is set
   always_comb
   begin
      next_assert = override_threshold ?
                    lbcr_field2(b2_thresh, ASSERT_LSB) : threshold_pin_assert; // [RQ3] [RQ1]
      next_deassert = override_threshold ?
                      lbcr_field2(b2_thresh, DEASSERT_LSB) : threshold_pin_deassert; // [RQ3] [RQ2]
      next_short = b3_swing[SHORT_BIT]; // [RQ9]
      next_swing = b3_swing[SWING_LSB +: 3]; // [RQ10]
      eff_mode = override_presence ?
                 lbcr_term_e'(lbcr_field2(b3_term, TERM_LSB)) : presence_pin; // [RQ7]
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lane_b2_assert_threshold <= 2'h0;
         lane_b2_deassert_threshold <= 2'h0;
         lane_b3_short_protect <= RST_B3_SWING[SHORT_BIT];
         lane_b3_output_swing <= RST_B3_SWING[SWING_LSB +: 3];
      end
      else
      begin
         lane_b2_assert_threshold <= next_assert;
         lane_b2_deassert_threshold <= next_deassert;
         lane_b3_short_protect <= next_short;
         lane_b3_output_swing <= next_swing;
      end
   end

   // ----------------------------------------------------------------
   // presence check sequencer
   // ----------------------------------------------------------------
   // the sequencer restarts on any change of the effective mode, so a
   // pin change or an override toggle that alters that mode to code 01 or 10 begins a fresh probe run
   lbcr_probe_seq #(
      .PERIOD_CYCLES(PROBE_CYCLES),
      .LIMIT(PROBE_TRIES)
   ) u_seq (
      .clk(clk),
      .rst_b(rst_b),
      .mode(eff_mode),
      .far_end_seen(far_end_seen),
      .probe(lane_b3_probe),
      .terminated(lane_b3_terminated)
   );

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [7:0] next_rdata;

   // read data registered; unmapped offsets answer zero
   always_comb
   begin
      next_rdata = reg_rdata;
      if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_B2_THRESH: next_rdata = b2_thresh;
            ADDR_RSVD_A: next_rdata = rsvd_a;
            ADDR_RSVD_B: next_rdata = rsvd_b;
            ADDR_B3_TERM: next_rdata = b3_term;
            ADDR_B3_EQ: next_rdata = lane_b3_equalizer;
            ADDR_B3_SWING: next_rdata = b3_swing;
            ADDR_B3_STATUS: next_rdata = {lane_b3_terminated, 7'h00}; // [RQ11]
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata <= 8'h00;
      end
      else
      begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_eq_write;
      @(posedge clk) disable iff (!rst_b)
      (reg_wr && reg_addr == ADDR_B3_EQ) |=> lane_b3_equalizer == $past(reg_wdata);
   endproperty
   a_eq_write: assert property (p_eq_write) else $error("equalizer not written"); // [RQ8]

   property p_short_write;
      @(posedge clk) disable iff (!rst_b)
      (reg_wr && reg_addr == ADDR_B3_SWING) |-> ##2
         lane_b3_short_protect == $past(reg_wdata[SHORT_BIT], 2);
   endproperty
   a_short_write: assert property (p_short_write) else $error("short protect wrong"); // [RQ9]

   property p_swing_write;
      @(posedge clk) disable iff (!rst_b)
      (reg_wr && reg_addr == ADDR_B3_SWING) |-> ##2
         lane_b3_output_swing == $past(reg_wdata[2:0], 2);
   endproperty
   a_swing_write: assert property (p_swing_write) else $error("swing code wrong"); // [RQ10]

   property p_assert_sel;
      @(posedge clk) disable iff (!rst_b)
      override_threshold |=> lane_b2_assert_threshold == $past(b2_thresh[3:2]);
   endproperty
   a_assert_sel: assert property (p_assert_sel) else $error("assert threshold wrong"); // [RQ1]

   property p_deassert_pin;
      @(posedge clk) disable iff (!rst_b)
      !override_threshold |=> lane_b2_deassert_threshold == $past(threshold_pin_deassert);
   endproperty
   a_deassert_pin: assert property (p_deassert_pin) else $error("pin not obeyed"); // [RQ3]

   property p_deassert_reg;
      @(posedge clk) disable iff (!rst_b)
      override_threshold |=> lane_b2_deassert_threshold == $past(b2_thresh[1:0]);
   endproperty
   a_deassert_reg: assert property (p_deassert_reg) else $error("de-assert wrong"); // [RQ2]

   property p_status_read;
      @(posedge clk) disable iff (!rst_b)
      (reg_rd && reg_addr == ADDR_B3_STATUS) |=>
         reg_rdata == {$past(lane_b3_terminated), 7'h00};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong"); // [RQ11]

   property p_pin_mode;
      @(posedge clk) disable iff (!rst_b)
      (!override_presence && presence_pin == TERM_50) [*3] |-> lane_b3_terminated;
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("pin mode ignored"); // [RQ7]

   c_override: cover property (@(posedge clk) disable iff (!rst_b)
      override_presence && b3_term[3:2] == 2'b10 ##1 lane_b3_probe);
   c_status: cover property (@(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == ADDR_B3_STATUS && lane_b3_terminated);
   c_swing: cover property (@(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == ADDR_B3_SWING);
endmodule

/* File: testbench/lbcr_far_end.sv */
/*
 Far-end receiver seen by the lane B3 output probe.
 Assumes the probe pulse lasts one clock and the answer is read in it.
*/
`timescale 1ns/1ps
module lbcr_far_end
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic probe,
   input wire logic present,
   output logic seen
);
   logic junk;

   // ----------------------------------------------------------------
   // answer line
   // ----------------------------------------------------------------
   // outside a probe the line carries a toggling pattern, never a hint
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         junk <= 1'b0;
      else
         junk <= ~junk;
   end
   assign seen = probe ? present : junk;
endmodule

/* File: testbench/tb_top.sv */
/*
 Self-checking bench for the lane B2/B3 configuration registers.
 Assumes short probe timing (20 cycles, 3 tries) set at the instance.
*/
`timescale 1ns/1ps
module tb_top;
   import lbcr_pkg::*;
   logic clk, rst_b, reg_wr, reg_rd, ovr_th, ovr_pr, present, seen;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, eq;
   logic [1:0] pin_a, pin_d, th_a, th_d;
   lbcr_term_e pin_p;
   logic short_p, probe, term;
   logic [2:0] swing;
   int error_cnt = 0;
   int comparisons = 0;
   int probe_cnt = 0;

   lbcr_regs #(.PROBE_CYCLES(20), .PROBE_TRIES(3)) lbcr_regs_inst
   (
      .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .override_threshold(ovr_th), .override_presence(ovr_pr),
      .threshold_pin_assert(pin_a), .threshold_pin_deassert(pin_d),
      .presence_pin(pin_p), .far_end_seen(seen),
      .lane_b2_assert_threshold(th_a), .lane_b2_deassert_threshold(th_d),
      .lane_b3_equalizer(eq), .lane_b3_short_protect(short_p),
      .lane_b3_output_swing(swing), .lane_b3_probe(probe),
      .lane_b3_terminated(term)
   );

   lbcr_far_end lbcr_far_end_inst
   (
      .clk(clk), .rst_b(rst_b), .probe(probe), .present(present), .seen(seen)
   );

   // ----------------------------------------------------------------
   // clock and probe counting
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
      if (probe === 1'b1)
         probe_cnt <= probe_cnt + 1;

   // ----------------------------------------------------------------
   // access and check tasks
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask

   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // strobe dropped then one idle edge, so calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_rd = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      chk("rdata", exp, reg_rdata);
      tick(1);
   endtask

   // bounded wait for the termination state
   task automatic wait_term(input logic exp, input int lim);
      int i;
      for (i = 0; i < lim && term !== exp; i++)
         tick(1);
      chk("terminated", {7'h00, exp}, {7'h00, term});
      // a used-up bound ends the run at once
      if (term !== exp)
         report_and_stop();
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin : main
      logic [7:0] rst_tab [7];
      rst_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h2F, 8'hAD, 8'h00};
      rst_b = 1'b0;
      {reg_wr, reg_rd, ovr_th, ovr_pr, present} = '0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      pin_a = 2'b01;
      pin_d = 2'b10;
      pin_p = TERM_HIZ;
      tick(12);
      rst_b = 1'b1;
      tick(2);
      // reset values of 0x20..0x26 and the equalizer, swing and short outputs
      for (int k = 0; k < 7; k++)
         rd(8'h20 + k[7:0], rst_tab[k]);
      chk("eq", 8'h2F, eq);
      chk("swing", {5'h00, 3'b101}, {5'h00, swing});
      chk("short", 8'h01, {7'h00, short_p});
      // thresholds: pins rule until the override bit is set
      // each register code differs from its own pin code so either source shows
      wr(8'h20, 8'h0D);
      rd(8'h20, 8'h0D);
      chk("assert_pin", 8'h01, {6'h00, th_a});
      chk("deassert_pin", 8'h02, {6'h00, th_d});
      ovr_th = 1'b1;
      tick(2);
      chk("assert_reg", 8'h03, {6'h00, th_a});
      chk("deassert_reg", 8'h01, {6'h00, th_d});
      // reserved bytes written with zeros, read-only and unmapped places
      wr(8'h21, 8'h00);
      wr(8'h22, 8'h00);
      rd(8'h21, 8'h00);
      wr(8'h26, 8'hFF);
      rd(8'h26, 8'h00);
      wr(8'h30, 8'h5A);
      rd(8'h30, 8'h00);
      // equalizer and swing byte
      wr(8'h24, 8'hC3);
      chk("eq", 8'hC3, eq);
      rd(8'h24, 8'hC3);
      wr(8'h25, 8'h2B);
      tick(1);
      chk("short", 8'h00, {7'h00, short_p});
      chk("swing", 8'h03, {5'h00, swing});
      wr(8'h25, 8'hAE);
      tick(1);
      chk("short", 8'h01, {7'h00, short_p});
      chk("swing", 8'h06, {5'h00, swing});
      // presence mode from pins while the override bit is clear
      wr(8'h23, 8'h0C);
      wait_term(1'b0, 5);
      pin_p = TERM_50;
      wait_term(1'b1, 5);
      rd(8'h26, 8'h80);
      pin_p = TERM_HIZ;
      wait_term(1'b0, 5);
      // register mode 11 then 00 under override
      ovr_pr = 1'b1;
      wait_term(1'b1, 5);
      wr(8'h23, 8'h00);
      wait_term(1'b0, 5);
      // limited run with no receiver: exactly three probes, stays open
      wr(8'h23, 8'h04);
      probe_cnt = 0;
      tick(150);
      chk("probes_limited", 8'h03, probe_cnt[7:0]);
      chk("terminated", 8'h00, {7'h00, term});
      // endless run keeps probing, then a receiver appears
      wr(8'h23, 8'h08);
      probe_cnt = 0;
      tick(150);
      chk("probes_endless", 8'h01, {7'h00, probe_cnt > 5});
      chk("terminated", 8'h00, {7'h00, term});
      present = 1'b1;
      wait_term(1'b1, 30);
      rd(8'h26, 8'h80);
      probe_cnt = 0;
      tick(60);
      chk("probes_after_hit", 8'h00, probe_cnt[7:0]);
      // limited run with receiver: mode change clears, then detects
      wr(8'h23, 8'h04);
      chk("terminated", 8'h00, {7'h00, term});
      wait_term(1'b1, 30);
      report_and_stop();
   end
endmodule
